// ---- design/splr_regs.svh ----
// command codes, register map and field constants for the protection and learning registers
`ifndef SPLR_REGS_SVH
`define SPLR_REGS_SVH

// link command codes
`define SPLR_PASSWORD_READ_CMD         8'he7
`define SPLR_PASSWORD_PROGRAM_CMD      8'he8
`define SPLR_GENERIC_REGISTER_READ_CMD 8'h65
`define SPLR_LOCK_READ_CMD             8'ha7
`define SPLR_LOCK_WRITE_CMD            8'ha6
`define SPLR_PERSISTENT_READ_CMD       8'hfc
`define SPLR_PERSISTENT_READ_WIDE_CMD  8'he2
`define SPLR_PERSISTENT_PROGRAM_CMD    8'hfd
`define SPLR_PERSISTENT_PROG_WIDE_CMD  8'he3
`define SPLR_PERSISTENT_ERASE_CMD      8'he4
`define SPLR_DYNAMIC_READ_CMD          8'hfa
`define SPLR_DYNAMIC_READ_WIDE_CMD     8'he0
`define SPLR_DYNAMIC_WRITE_CMD         8'hfb
`define SPLR_DYNAMIC_WRITE_WIDE_CMD    8'he1
`define SPLR_NV_PATTERN_PROGRAM_CMD    8'h43
`define SPLR_VOL_PATTERN_WRITE_CMD     8'h4a
`define SPLR_PATTERN_READ_CMD          8'h41
`define SPLR_MODE_PROGRAM_CMD          8'h2f
`define SPLR_DDR_DUMMY_READ_CMD        8'hee

// protect-bit byte encodings, delivered states, sector field position and dummy edge count
`define SPLR_BYTE_PROTECTED            8'h00
`define SPLR_BYTE_UNPROTECTED          8'hff
`define SPLR_PASSWORD_RST              64'hffff_ffff_ffff_ffff
`define SPLR_MODE_RST                  2'b11
`define SPLR_NV_PATTERN_RST            8'h00
`define SPLR_DYNAMIC_RST               1'b1
`define SPLR_SECTOR_LSB                16
`define SPLR_DUMMY_EDGES               4'h8

// generic register read map (address low byte)
`define SPLR_GEN_PASSWORD_BASE         8'h00
`define SPLR_GEN_LOCK                  8'h08
`define SPLR_GEN_NV_PATTERN            8'h09
`define SPLR_GEN_VOL_PATTERN           8'h0a
`define SPLR_GEN_MODE                  8'h0b

// host controller apb map
`define SPLR_HOST_CTRL                 8'h00
`define SPLR_HOST_ADDR                 8'h04
`define SPLR_HOST_TX_LO                8'h08
`define SPLR_HOST_TX_HI                8'h0c
`define SPLR_HOST_RX_LO                8'h10
`define SPLR_HOST_RX_HI                8'h14
`define SPLR_HOST_STATUS               8'h18
`define SPLR_CTRL_CMD_LSB              0
`define SPLR_CTRL_NADDR_LSB            8
`define SPLR_CTRL_NTX_LSB              11
`define SPLR_CTRL_NRX_LSB              15
`define SPLR_CTRL_START_BIT            31
`define SPLR_STATUS_LEARN_LSB          8

`endif

// ---- design/splr_pkg.sv ----
// shared types of the protection and learning register link
package splr_pkg;
  typedef enum logic [5:0] {
    SPLR_D_CMD   = 6'h01,
    SPLR_D_ADDR  = 6'h02,
    SPLR_D_DIN   = 6'h04,
    SPLR_D_DOUT  = 6'h08,
    SPLR_D_DUMMY = 6'h10,
    SPLR_D_SKIP  = 6'h20
  } splr_dev_state_t;

  typedef enum logic [3:0] {
    SPLR_H_IDLE  = 4'h1,
    SPLR_H_SHIFT = 4'h2,
    SPLR_H_DUMMY = 4'h4,
    SPLR_H_GAP   = 4'h8
  } splr_host_state_t;
endpackage

// ---- design/splr_if.sv ----
// serial link between the flash register end and the host controller end
`timescale 1ns/100ps
interface splr_if;
  logic       cs_n;
  logic       sck;
  logic       mosi;
  logic       miso_o;
  logic       miso_oe_n;
  logic       miso;
  logic [3:0] dq_o;
  logic       dq_oe_n;
  logic [3:0] dq;

  // undriven lines read as pulled up
  assign miso = miso_oe_n ? 1'b1 : miso_o;
  assign dq   = dq_oe_n ? 4'hf : dq_o;

  modport device (input cs_n, input sck, input mosi,
                  output miso_o, output miso_oe_n, output dq_o, output dq_oe_n);
  modport host (output cs_n, output sck, output mosi, input miso, input dq);
endinterface

// ---- design/splr_device.sv ----
// flash end: password store, lock, protect bits and learning pattern registers
//
// Design decisions made here: the serial frame decoder and the generic register read map.
`timescale 1ns/100ps
`include "splr_regs.svh"
module splr_device
  import splr_pkg::*;
#(
  parameter int NSECT = 128
) (
  // clock and resets (factory_rst_n models delivery of the non-volatile cells)
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     factory_rst_n,
  // serial link
  splr_if.device                        lnk,
  // user side sector status
  input  wire logic [$clog2(NSECT)-1:0] query_sector,
  output logic                          query_protected
);
  localparam int SW = $clog2(NSECT);

  if (NSECT < 2 || NSECT > 256)
  begin : g_chk
    $error("NSECT must lie in 2..256");
  end

  logic [2:0]      sync1_reg;
  logic [2:0]      sync2_reg;
  logic [2:0]      sync3_reg;
  splr_dev_state_t state_reg;
  logic [2:0]      bit_reg;
  logic [2:0]      cnt_reg;
  logic [3:0]      dum_reg;
  logic [7:0]      cmd_reg;
  logic [6:0]      rx_reg;
  logic [31:0]     addr_reg;
  logic [7:0]      tx_reg;
  logic [63:0]     pass_reg;
  logic [1:0]      mode_reg;
  logic [NSECT-1:0] ppb_reg;
  logic [7:0]      nvp_reg;
  logic            nvp_done_reg;
  logic            lock_reg;
  logic [NSECT-1:0] dyb_reg;
  logic [7:0]      vol_reg;
  logic            init_reg;
  logic            miso_o_reg;
  logic            miso_oe_n_reg;
  logic [3:0]      dq_o_reg;
  logic            dq_oe_n_reg;
  logic            query_protected_reg;

  logic            cs_idle;
  logic            rise;
  logic            fall;
  logic            byte_done;
  logic [7:0]      byte_in;
  logic [31:0]     addr_full;
  logic [SW-1:0]   sect_full;
  logic [SW-1:0]   sect;
  logic [7:0]      resp;
  logic [2:0]      nad;

  // sync order: {cs_n, sck, mosi}; only sync2/sync3 feed logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 3'h4;
      sync2_reg <= 3'h4;
      sync3_reg <= 3'h4;
    end
    else
    begin
      sync1_reg <= {lnk.cs_n, lnk.sck, lnk.mosi};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign cs_idle   = sync2_reg[2];
  assign rise      = !cs_idle && sync2_reg[1] && !sync3_reg[1];
  assign fall      = !cs_idle && !sync2_reg[1] && sync3_reg[1];
  assign byte_done = rise && bit_reg == 3'h7;
  assign byte_in   = {rx_reg, sync2_reg[0]};
  assign addr_full = {addr_reg[23:0], byte_in};
  assign sect_full = addr_full[`SPLR_SECTOR_LSB +: SW];
  assign sect      = addr_reg[`SPLR_SECTOR_LSB +: SW];

  function automatic logic [2:0] addr_bytes(input logic [7:0] c);
    case (c)
      `SPLR_PERSISTENT_READ_WIDE_CMD, `SPLR_PERSISTENT_PROG_WIDE_CMD,
      `SPLR_DYNAMIC_READ_WIDE_CMD, `SPLR_DYNAMIC_WRITE_WIDE_CMD: addr_bytes = 3'h4;
      `SPLR_PERSISTENT_READ_CMD, `SPLR_PERSISTENT_PROGRAM_CMD,
      `SPLR_DYNAMIC_READ_CMD, `SPLR_DYNAMIC_WRITE_CMD,
      `SPLR_GENERIC_REGISTER_READ_CMD: addr_bytes = 3'h3;
      default: addr_bytes = 3'h0;
    endcase
  endfunction

  // generic register view; the password is hidden once password mode is locked in
  function automatic logic [7:0] reg_byte(input logic [7:0] a);
    if (a[7:3] == 5'h00)
      reg_byte = mode_reg[1] ? pass_reg[{a[2:0], 3'h0} +: 8] : 8'hff;
    else if (a == `SPLR_GEN_LOCK)
      reg_byte = {7'h00, lock_reg};
    else if (a == `SPLR_GEN_NV_PATTERN)
      reg_byte = nvp_reg;
    else if (a == `SPLR_GEN_VOL_PATTERN)
      reg_byte = vol_reg;
    else if (a == `SPLR_GEN_MODE)
      reg_byte = {5'h1f, mode_reg, 1'b1};
    else
      reg_byte = 8'hff;
  endfunction

  assign nad = addr_bytes(cmd_reg);

  always_comb
  begin
    case (cmd_reg)
      `SPLR_PASSWORD_READ_CMD: resp = reg_byte({5'h00, cnt_reg});
      `SPLR_GENERIC_REGISTER_READ_CMD: resp = reg_byte(addr_reg[7:0] + {5'h00, cnt_reg});
      `SPLR_LOCK_READ_CMD: resp = reg_byte(`SPLR_GEN_LOCK);
      `SPLR_PERSISTENT_READ_CMD, `SPLR_PERSISTENT_READ_WIDE_CMD:
        resp = ppb_reg[sect] ? `SPLR_BYTE_UNPROTECTED : `SPLR_BYTE_PROTECTED;
      `SPLR_DYNAMIC_READ_CMD, `SPLR_DYNAMIC_READ_WIDE_CMD:
        resp = dyb_reg[sect] ? `SPLR_BYTE_UNPROTECTED : `SPLR_BYTE_PROTECTED;
      `SPLR_PATTERN_READ_CMD: resp = vol_reg;
      default: resp = 8'hff;
    endcase
  end

  // frame decoder: commands act on the completing byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= SPLR_D_CMD;
      bit_reg   <= 3'h0;
      cnt_reg   <= 3'h0;
      dum_reg   <= 4'h0;
      cmd_reg   <= 8'h00;
      rx_reg    <= 7'h00;
      addr_reg  <= 32'h0000_0000;
    end
    else if (cs_idle)
    begin
      state_reg <= SPLR_D_CMD;
      bit_reg   <= 3'h0;
      cnt_reg   <= 3'h0;
      dum_reg   <= 4'h0;
    end
    else
    begin
      if (rise)
      begin
        bit_reg <= bit_reg + 3'h1;
        rx_reg  <= byte_in[6:0];
      end
      if (state_reg == SPLR_D_DUMMY && (rise || fall) && dum_reg != `SPLR_DUMMY_EDGES)
        dum_reg <= dum_reg + 4'h1;
      if (byte_done)
      begin
        cnt_reg <= cnt_reg + 3'h1;
        unique case (state_reg)
          SPLR_D_CMD:
          begin
            cmd_reg <= byte_in;
            cnt_reg <= 3'h0;
            if (addr_bytes(byte_in) != 3'h0)
              state_reg <= SPLR_D_ADDR;
            else
            begin
              case (byte_in)
                `SPLR_PASSWORD_READ_CMD, `SPLR_LOCK_READ_CMD,
                `SPLR_PATTERN_READ_CMD: state_reg <= SPLR_D_DOUT;
                `SPLR_PASSWORD_PROGRAM_CMD, `SPLR_NV_PATTERN_PROGRAM_CMD,
                `SPLR_VOL_PATTERN_WRITE_CMD,
                `SPLR_MODE_PROGRAM_CMD: state_reg <= SPLR_D_DIN;
                `SPLR_DDR_DUMMY_READ_CMD: state_reg <= SPLR_D_DUMMY;
                default: state_reg <= SPLR_D_SKIP;
              endcase
            end
          end
          SPLR_D_ADDR:
          begin
            addr_reg <= addr_full;
            if (cnt_reg + 3'h1 == nad)
            begin
              cnt_reg <= 3'h0;
              case (cmd_reg)
                `SPLR_DYNAMIC_WRITE_CMD, `SPLR_DYNAMIC_WRITE_WIDE_CMD: state_reg <= SPLR_D_DIN;
                `SPLR_PERSISTENT_PROGRAM_CMD,
                `SPLR_PERSISTENT_PROG_WIDE_CMD: state_reg <= SPLR_D_SKIP;
                default: state_reg <= SPLR_D_DOUT;
              endcase
            end
          end
          SPLR_D_DIN:
            if (cmd_reg != `SPLR_PASSWORD_PROGRAM_CMD || cnt_reg == 3'h7)
              state_reg <= SPLR_D_SKIP;
          SPLR_D_DOUT, SPLR_D_DUMMY, SPLR_D_SKIP: ;
        endcase
      end
    end
  end

  // non-volatile cells survive presetn; only factory_rst_n restores delivery state
  always_ff @(posedge pclk or negedge factory_rst_n)
  begin
    if (!factory_rst_n)
    begin
      pass_reg     <= `SPLR_PASSWORD_RST;
      mode_reg     <= `SPLR_MODE_RST;
      ppb_reg      <= {NSECT{1'b1}};
      nvp_reg      <= `SPLR_NV_PATTERN_RST;
      nvp_done_reg <= 1'b0;
    end
    else if (byte_done)
    begin
      if (state_reg == SPLR_D_CMD && byte_in == `SPLR_PERSISTENT_ERASE_CMD && lock_reg)
        ppb_reg <= {NSECT{1'b1}};
      if (state_reg == SPLR_D_ADDR && cnt_reg + 3'h1 == nad && lock_reg &&
          (cmd_reg == `SPLR_PERSISTENT_PROGRAM_CMD ||
           cmd_reg == `SPLR_PERSISTENT_PROG_WIDE_CMD))
        ppb_reg[sect_full] <= 1'b0;
      if (state_reg == SPLR_D_DIN)
      begin
        // otp cells can only clear; closed once a protection mode is chosen
        if (cmd_reg == `SPLR_PASSWORD_PROGRAM_CMD && mode_reg == 2'b11)
          pass_reg[{cnt_reg, 3'h0} +: 8] <= pass_reg[{cnt_reg, 3'h0} +: 8] & byte_in;
        if (cmd_reg == `SPLR_NV_PATTERN_PROGRAM_CMD && !nvp_done_reg)
        begin
          nvp_reg      <= byte_in;
          nvp_done_reg <= 1'b1;
        end
        if (cmd_reg == `SPLR_MODE_PROGRAM_CMD && mode_reg == 2'b11 && byte_in[2:1] != 2'b00)
          mode_reg <= byte_in[2:1];
      end
    end
  end

  // volatile state: lock and pattern reload happen one clock after presetn release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_reg <= 1'b0;
      lock_reg <= 1'b0;
      dyb_reg  <= {NSECT{`SPLR_DYNAMIC_RST}};
      vol_reg  <= 8'h00;
    end
    else if (!init_reg)
    begin
      init_reg <= 1'b1;
      lock_reg <= mode_reg[1];
      vol_reg  <= nvp_reg;
    end
    else if (byte_done)
    begin
      if (state_reg == SPLR_D_CMD && byte_in == `SPLR_LOCK_WRITE_CMD)
        lock_reg <= 1'b0;
      if (state_reg == SPLR_D_DIN)
      begin
        if (cmd_reg == `SPLR_DYNAMIC_WRITE_CMD || cmd_reg == `SPLR_DYNAMIC_WRITE_WIDE_CMD)
        begin
          if (byte_in == `SPLR_BYTE_PROTECTED)
            dyb_reg[sect] <= 1'b0;
          else if (byte_in == `SPLR_BYTE_UNPROTECTED)
            dyb_reg[sect] <= 1'b1;
        end
        if (cmd_reg == `SPLR_VOL_PATTERN_WRITE_CMD ||
            (cmd_reg == `SPLR_NV_PATTERN_PROGRAM_CMD && !nvp_done_reg))
          vol_reg <= byte_in;
      end
    end
  end

  // pin drivers: miso changes on sck fall, a nonzero pattern on the first eight edges of the dummy phase, then released
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      miso_o_reg          <= 1'b1;
      miso_oe_n_reg       <= 1'b1;
      dq_o_reg            <= 4'hf;
      dq_oe_n_reg         <= 1'b1;
      query_protected_reg <= 1'b0;
    end
    else
    begin
      query_protected_reg <= !ppb_reg[query_sector] || !dyb_reg[query_sector];
      if (cs_idle)
      begin
        miso_oe_n_reg <= 1'b1;
        dq_oe_n_reg   <= 1'b1;
      end
      else if (state_reg == SPLR_D_DOUT && fall)
      begin
        miso_oe_n_reg <= 1'b0;
        if (bit_reg == 3'h0)
        begin
          tx_reg     <= resp;
          miso_o_reg <= resp[7];
        end
        else
          miso_o_reg <= tx_reg[3'h7 - bit_reg];
      end
      else if (state_reg == SPLR_D_DUMMY && (rise || fall))
      begin
        if (dum_reg == `SPLR_DUMMY_EDGES)
          dq_oe_n_reg <= 1'b1;
        else
        begin
          dq_o_reg    <= {4{vol_reg[3'h7 - dum_reg[2:0]]}};
          dq_oe_n_reg <= vol_reg == 8'h00;
        end
      end
    end
  end

  assign lnk.miso_o    = miso_o_reg;
  assign lnk.miso_oe_n = miso_oe_n_reg;
  assign lnk.dq_o      = dq_o_reg;
  assign lnk.dq_oe_n   = dq_oe_n_reg;
  assign query_protected = query_protected_reg;
endmodule

// ---- design/splr_host.sv ----
// host end: apb-programmed controller that runs one serial frame per start
`timescale 1ns/100ps
`include "splr_regs.svh"
module splr_host
  import splr_pkg::*;
#(
  parameter int SCK_HALF = 8
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  splr_if.host             lnk
);
  if (SCK_HALF < 8 || SCK_HALF > 255)
  begin : g_chk
    $error("SCK_HALF must lie in 8..255 to cover the round trip");
  end

  splr_host_state_t state_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] addr_reg;
  logic [63:0] tx_reg;
  logic [63:0] rx_reg;
  logic [7:0]  learn_reg;
  logic [7:0]  div_reg;
  logic [2:0]  bit_reg;
  logic [4:0]  byte_reg;
  logic [3:0]  edge_reg;
  logic        sck_reg;
  logic        cs_n_reg;
  logic        mosi_reg;
  logic [1:0]  s1_reg;
  logic [1:0]  s2_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        tick;
  logic        wr;
  logic        start;
  logic [2:0]  nad;
  logic [3:0]  ntx;
  logic [3:0]  nrx;
  logic [4:0]  total;
  logic [4:0]  rx_first;
  logic [4:0]  rx_idx;
  logic [7:0]  cur_byte;
  logic [7:0]  next_byte;

  assign nad      = ctrl_reg[`SPLR_CTRL_NADDR_LSB +: 3];
  assign ntx      = ctrl_reg[`SPLR_CTRL_NTX_LSB +: 4];
  assign nrx      = ctrl_reg[`SPLR_CTRL_NRX_LSB +: 4];
  assign rx_first = 5'h01 + {2'h0, nad} + {1'b0, ntx};
  assign total    = rx_first + {1'b0, nrx};
  assign rx_idx   = byte_reg - rx_first;
  assign tick     = div_reg == 8'(SCK_HALF - 1);
  assign wr       = psel && penable && pready_reg && pwrite;
  assign start    = wr && paddr == `SPLR_HOST_CTRL && pwdata[`SPLR_CTRL_START_BIT] &&
                    state_reg == SPLR_H_IDLE;

  // byte k of the frame: command, address msb first, then payload lsb byte first
  function automatic logic [7:0] frame_byte(input logic [4:0] k);
    logic [4:0] t;
    t = k - 5'h01 - {2'h0, nad};
    if (k == 5'h00)
      frame_byte = ctrl_reg[`SPLR_CTRL_CMD_LSB +: 8];
    else if (k <= {2'h0, nad})
      frame_byte = addr_reg[{2'(nad - k[2:0]), 3'h0} +: 8];
    else if (t < {1'b0, ntx})
      frame_byte = tx_reg[{t[2:0], 3'h0} +: 8];
    else
      frame_byte = 8'h00;
  endfunction

  // always_comb so that changes of ctrl, address and tx words reach the bytes
  always_comb
  begin
    cur_byte  = frame_byte(byte_reg);
    next_byte = frame_byte(byte_reg + 5'h01);
  end

  // apb: zero wait state, read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      ctrl_reg    <= 32'h0000_0000;
      addr_reg    <= 32'h0000_0000;
      tx_reg      <= 64'h0;
    end
    else
    begin
      pready_reg  <= psel && !penable;
      pslverr_reg <= psel && !penable && (paddr > `SPLR_HOST_STATUS || paddr[1:0] != 2'h0);
      if (psel && !penable)
      begin
        case (paddr)
          `SPLR_HOST_CTRL: prdata_reg <= ctrl_reg;
          `SPLR_HOST_ADDR: prdata_reg <= addr_reg;
          `SPLR_HOST_TX_LO: prdata_reg <= tx_reg[31:0];
          `SPLR_HOST_TX_HI: prdata_reg <= tx_reg[63:32];
          `SPLR_HOST_RX_LO: prdata_reg <= rx_reg[31:0];
          `SPLR_HOST_RX_HI: prdata_reg <= rx_reg[63:32];
          `SPLR_HOST_STATUS:
            prdata_reg <= {16'h0000, learn_reg, 7'h00, state_reg != SPLR_H_IDLE};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
      // setup registers are frozen while a frame runs
      if (wr && state_reg == SPLR_H_IDLE)
      begin
        case (paddr)
          `SPLR_HOST_CTRL: ctrl_reg <= {1'b0, pwdata[30:0]};
          `SPLR_HOST_ADDR: addr_reg <= pwdata;
          `SPLR_HOST_TX_LO: tx_reg[31:0] <= pwdata;
          `SPLR_HOST_TX_HI: tx_reg[63:32] <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // {miso, dq[0]} pass two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= 2'h3;
      s2_reg <= 2'h3;
    end
    else
    begin
      s1_reg <= {lnk.miso, lnk.dq[0]};
      s2_reg <= s1_reg;
    end
  end

  // frame engine: mosi set with sck low, miso sampled as sck rises
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= SPLR_H_IDLE;
      div_reg   <= 8'h00;
      bit_reg   <= 3'h0;
      byte_reg  <= 5'h00;
      edge_reg  <= 4'h0;
      sck_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      mosi_reg  <= 1'b0;
      rx_reg    <= 64'h0;
      learn_reg <= 8'h00;
    end
    else
    begin
      div_reg <= (state_reg == SPLR_H_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
      unique case (state_reg)
        SPLR_H_IDLE:
          if (start)
          begin
            state_reg <= SPLR_H_SHIFT;
            cs_n_reg  <= 1'b0;
            mosi_reg  <= pwdata[`SPLR_CTRL_CMD_LSB + 7];
            bit_reg   <= 3'h0;
            byte_reg  <= 5'h00;
            edge_reg  <= 4'h0;
          end
        SPLR_H_SHIFT:
          if (tick && !sck_reg)
          begin
            sck_reg <= 1'b1;
            if (byte_reg >= rx_first)
              rx_reg[{rx_idx[2:0], ~bit_reg}] <= s2_reg[1];
          end
          else if (tick)
          begin
            sck_reg <= 1'b0;
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg != 3'h7)
              mosi_reg <= cur_byte[3'h6 - bit_reg];
            else if (byte_reg + 5'h01 != total)
            begin
              byte_reg <= byte_reg + 5'h01;
              mosi_reg <= next_byte[7];
            end
            else if (ctrl_reg[`SPLR_CTRL_CMD_LSB +: 8] == `SPLR_DDR_DUMMY_READ_CMD)
              state_reg <= SPLR_H_DUMMY;
            else
            begin
              state_reg <= SPLR_H_GAP;
              cs_n_reg  <= 1'b1;
            end
          end
        SPLR_H_DUMMY:
          if (tick)
          begin
            // each edge sees the bit the flash set on the edge before
            sck_reg  <= !sck_reg;
            edge_reg <= edge_reg + 4'h1;
            // the flash drives its first bit on the fall that closes the command
            if (edge_reg <= 4'h7)
              learn_reg <= {learn_reg[6:0], s2_reg[0]};
            if (edge_reg == 4'h9)
            begin
              state_reg <= SPLR_H_GAP;
              cs_n_reg  <= 1'b1;
            end
          end
        SPLR_H_GAP:
          if (tick)
            state_reg <= SPLR_H_IDLE;
      endcase
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign lnk.cs_n = cs_n_reg;
  assign lnk.sck  = sck_reg;
  assign lnk.mosi = mosi_reg;
endmodule

// ---- tb/splr_link_chk.sv ----
// link protocol assertions watching the shared serial interface
`timescale 1ns/100ps
module splr_link_chk (
  // clock, reset and link lines
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       mosi,
  input wire logic       miso_o,
  input wire logic       miso_oe_n,
  input wire logic [3:0] dq_o,
  input wire logic       dq_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence sck_hi2; sck ##1 sck; endsequence
  sequence idle4; cs_n [*4]; endsequence
  sck_idle_a: assert property (cs_n |-> !sck) else $error("sck moves outside a frame");
  sck_half_a: assert property ($rose(sck) |-> sck [*8] ##1 !sck) else $error("bad sck high");
  mosi_hold_a: assert property (sck_hi2 |-> $stable(mosi)) else $error("mosi moved");
  miso_hold_a: assert property (sck_hi2 |-> $stable(miso_o)) else $error("miso moved");
  cs_fall_a: assert property ($fell(cs_n) |-> !sck ##1 !sck) else $error("frame opens high");
  miso_rel_a: assert property (idle4 |-> miso_oe_n) else $error("miso held idle");
  dq_rel_a: assert property (idle4 |-> dq_oe_n) else $error("dq held idle");
  dq_same_a: assert property (!dq_oe_n |-> dq_o == 4'h0 || dq_o == 4'hf)
    else $error("dq lines differ");
endmodule

// ---- tb/testbench.sv ----
// self-checking bench joining the host controller end and the flash register end
`timescale 1ns/100ps
module testbench;
  logic        pclk, presetn, frst_n, psel, penable, pwrite, pready, pslverr, qp, qe;
  logic [7:0]  paddr;
  logic [6:0]  qs;
  logic [31:0] pwdata, prdata, q;
  int          errors, n_tests;
  splr_if lnk ();
  splr_device i_splr_device (.pclk(pclk), .presetn(presetn), .factory_rst_n(frst_n),
    .lnk(lnk), .query_sector(qs), .query_protected(qp));
  splr_host i_splr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  splr_link_chk chk (.pclk(pclk), .presetn(presetn), .cs_n(lnk.cs_n), .sck(lnk.sck),
    .mosi(lnk.mosi), .miso_o(lnk.miso_o), .miso_oe_n(lnk.miso_oe_n), .dq_o(lnk.dq_o),
    .dq_oe_n(lnk.dq_oe_n));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic close_out;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic c8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    logic hit;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    hit = pready;
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (hit !== 1'b1)
    begin
      errors++;
      close_out;
    end
  endtask
  // one frame: loads address and data, starts, polls busy, leaves rx low word in q
  task automatic frm(input int c, na, nt, nr, input logic [31:0] a, input logic [63:0] t);
    int k;
    apb(1'b1, 8'h04, a);
    apb(1'b1, 8'h08, t[31:0]);
    apb(1'b1, 8'h0c, t[63:32]);
    apb(1'b1, 8'h00, {1'b1, 12'h000, 4'(nr), 4'(nt), 3'(na), 8'(c)});
    k = 0;
    do
    begin
      apb(1'b0, 8'h18, 32'h0);
      k++;
    end
    while (q[0] !== 1'b0 && k < 3000);
    if (q[0] !== 1'b0)
    begin
      errors++;
      close_out;
    end
    apb(1'b0, 8'h10, 32'h0);
  endtask
  task automatic pulse_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_defaults;
    frm('ha7, 0, 0, 1, 0, 0);
    c8(q[7:0], 8'h01);
    frm('h41, 0, 0, 1, 0, 0);
    c8(q[7:0], 8'h00);
    frm('hfc, 3, 0, 1, 'h50000, 0);
    c8(q[7:0], 8'hff);
    frm('hfa, 3, 0, 1, 'h30000, 0);
    c8(q[7:0], 8'hff);
    apb(1'b0, 8'h1c, 32'h0);
    c8({7'h0, qe}, 8'h01);
  endtask
  task automatic t_protect;
    frm('hfd, 3, 0, 0, 'h50000, 0);
    frm('hfc, 3, 0, 1, 'h50000, 0);
    c8(q[7:0], 8'h00);
    qs <= 7'd5;
    repeat (3) @(posedge pclk);
    c8({7'h0, qp}, 8'h01);
    frm('he4, 0, 0, 0, 0, 0);
    frm('he2, 4, 0, 1, 'h50000, 0);
    c8(q[7:0], 8'hff);
    c8({7'h0, qp}, 8'h00);
    frm('hfb, 3, 1, 0, 'h30000, 0);
    frm('he0, 4, 0, 1, 'h30000, 0);
    c8(q[7:0], 8'h00);
    frm('he1, 4, 1, 0, 'h30000, 'hff);
    frm('hfa, 3, 0, 1, 'h30000, 0);
    c8(q[7:0], 8'hff);
    frm('ha6, 0, 0, 0, 0, 0);
    frm('ha7, 0, 0, 1, 0, 0);
    c8(q[7:0], 8'h00);
    frm('he3, 4, 0, 0, 'h50000, 0);
    frm('hfc, 3, 0, 1, 'h50000, 0);
    c8(q[7:0], 8'hff);
  endtask
  task automatic t_pattern;
    frm('h4a, 0, 1, 0, 0, 'h34);
    frm('h41, 0, 0, 1, 0, 0);
    c8(q[7:0], 8'h34);
    frm('hee, 0, 0, 0, 0, 0);
    apb(1'b0, 8'h18, 32'h0);
    c8(q[15:8], 8'h34);
    frm('h4a, 0, 1, 0, 0, 'h00);
    frm('hee, 0, 0, 0, 0, 0);
    apb(1'b0, 8'h18, 32'h0);
    c8(q[15:8], 8'hff);
    frm('h43, 0, 1, 0, 0, 'h5a);
    frm('h41, 0, 0, 1, 0, 0);
    c8(q[7:0], 8'h5a);
    frm('h43, 0, 1, 0, 0, 'ha5);
    frm('h65, 3, 0, 1, 'h09, 0);
    c8(q[7:0], 8'h5a);
    frm('h4a, 0, 1, 0, 0, 'h77);
    pulse_reset;
    frm('h41, 0, 0, 1, 0, 0);
    c8(q[7:0], 8'h5a);
  endtask
  task automatic t_password;
    frm('he8, 0, 8, 0, 0, 'h1122334455667788);
    frm('he7, 0, 0, 1, 0, 0);
    c8(q[7:0], 8'h88);
    frm('h65, 3, 0, 1, 'h07, 0);
    c8(q[7:0], 8'h11);
    frm('h2f, 0, 1, 0, 0, 'hfb);
    frm('he7, 0, 0, 1, 0, 0);
    c8(q[7:0], 8'hff);
    pulse_reset;
    frm('ha7, 0, 0, 1, 0, 0);
    c8(q[7:0], 8'h00);
  endtask
  initial
  begin
    errors = 0;
    n_tests = 0;
    presetn = 1'b0;
    frst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    qs = 7'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    frst_n <= 1'b1;
    repeat (4) @(posedge pclk);
    t_defaults;
    t_protect;
    t_pattern;
    t_password;
    close_out;
  end
endmodule
